// ### design/contact_pkg.sv
// Constants for the contact input conditioner: register map, fields, resets, timing.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package contact_pkg;
  // Clock and time base
  localparam int CLK_NS      = 20;
  localparam int MS_NS       = 1000000;
  localparam int MS_CYCLES   = MS_NS / CLK_NS;
  localparam int DS_MS       = 100;
  localparam int S_MS        = 1000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BLOCK  = 8'h04;
  localparam logic [7:0] OFS_TRIG   = 8'h08;
  localparam logic [7:0] OFS_MINSIG = 8'h0c;
  localparam logic [7:0] OFS_LONG   = 8'h10;
  localparam logic [7:0] OFS_WAIT   = 8'h14;
  localparam logic [7:0] OFS_RESCAN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Control field positions
  localparam int CTRL_ALLOW_BLK = 0;
  localparam int CTRL_BLK_EN    = 1;
  localparam int CTRL_TRIG_EN   = 2;
  localparam int CTRL_LONG_EN   = 3;
  localparam int CTRL_MINSIG_EN = 4;
  localparam int CTRL_SCAN_EN   = 5;
  localparam int CTRL_DEB_LO    = 8;
  localparam int RESCAN_NOW     = 0;
  localparam int RESCAN_RECOVER = 1;
  // Masks and reset values
  localparam logic [31:0] CTRL_MASK   = 32'h0000_073f;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0300;
  localparam logic [31:0] MINSIG_RST  = 32'h000a_000a;
  localparam logic [31:0] LONG_MASK   = 32'h0000_ffff;
  localparam logic [31:0] LONG_RST    = 32'h0000_0190;
  localparam logic [15:0] WAIT_MAX    = 16'h7530;
  localparam logic [15:0] WAIT_RST    = 16'h0000;
  // Debounce choices in ms, index from the control field
  localparam logic [15:0] DEB_MS [8] = '{16'h000a, 16'h0014, 16'h001e, 16'h0032,
                                         16'h0046, 16'h0064, 16'h0096, 16'h0096};
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ST_IDLE, ST_FILTER} mode_t;
endpackage
`default_nettype wire

// ### design/timer_if.sv
// Link between the conditioner and one of its countdown timers.
// Assumes both ends share the system clock.
`default_nettype none
interface timer_if;
  logic        load;
  logic [15:0] value;
  logic        step;
  logic        busy;
  logic        done;
  modport ctl (output load, output value, output step, input busy, input done);
  modport tmr (input load, input value, input step, output busy, output done);
endinterface
`default_nettype wire

// ### design/tick_gen.sv
// Prescaler: one tick pulse every DIV input steps.
// Assumes step is synchronous to clk.
`default_nettype none
module tick_gen #(
  parameter int DIV = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic step,
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } state_t;
  state_t st_reg;
  state_t st_next;

  // Count steps, wrap with a pulse
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (step) begin
      if (st_reg.cnt == W'(DIV - 1)) begin
        st_next.cnt  = '0;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule
`default_nettype wire

// ### design/step_timer.sv
// Countdown timer in units of the step pulse, restartable by load.
// Assumes load and step come from the same clock domain.
`default_nettype none
module step_timer (
  input  wire logic clk,
  input  wire logic rst_n,
  timer_if.tmr      t
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } state_t;
  state_t st_reg;
  state_t st_next;

  // Load restarts from the new value; zero ends at once
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (t.load) begin
      st_next.cnt  = t.value;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt == 16'h0000) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else if (t.step) begin
        st_next.cnt = st_reg.cnt - 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign t.busy = st_reg.busy;
  assign t.done = st_reg.done;
endmodule
`default_nettype wire

// ### design/contact_input_conditioner.sv
// Contact input conditioner with AXI4-Lite registers and event outputs.
// Assumes CONTACT is synchronous to MCLK, high meaning contact closed.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
module contact_input_conditioner #(
  parameter int MS_CYCLES = contact_pkg::MS_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  input  wire logic        CONTACT,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             EVT_VALID,
  output logic             EVT_VALUE,
  output logic             EVT_LONG,
  output logic             SWITCH_STATE
);
  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                aw_have;
    logic                w_have;
    logic [7:0]          awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic [31:0]         ctrl;
    logic [31:0]         minsig;
    logic [31:0]         longt;
    logic [15:0]         waitt;
    logic                blk;
    logic                trig_pend;
    logic                trig_val;
    logic                scan_pend;
    logic                lvl;
    contact_pkg::mode_t  mode;
    logic                pend_val;
    logic                pressing;
    logic                evt_valid;
    logic                evt_value;
    logic                evt_long;
    logic                sw_state;
  } state_t;
  state_t st_reg;
  state_t st_next;

  logic ms_tick;
  logic ds_tick;
  logic s_tick;
  timer_if deb_t ();
  timer_if min_t ();
  timer_if long_t ();
  timer_if wait_t ();

  // Time bases: 1 ms, 100 ms and 1 s
  tick_gen #(.DIV(MS_CYCLES)) ms_gen (
    .clk   (MCLK),
    .rst_n (ARST_N),
    .step  (1'b1),
    .tick  (ms_tick)
  );
  tick_gen #(.DIV(contact_pkg::DS_MS)) ds_gen (
    .clk   (MCLK),
    .rst_n (ARST_N),
    .step  (ms_tick),
    .tick  (ds_tick)
  );
  tick_gen #(.DIV(contact_pkg::S_MS)) s_gen (
    .clk   (MCLK),
    .rst_n (ARST_N),
    .step  (ms_tick),
    .tick  (s_tick)
  );

  // Debounce, minimum signal, long press and recovery wait timers
  step_timer deb_tmr (.clk(MCLK), .rst_n(ARST_N), .t(deb_t.tmr));
  step_timer min_tmr (.clk(MCLK), .rst_n(ARST_N), .t(min_t.tmr));
  step_timer long_tmr (.clk(MCLK), .rst_n(ARST_N), .t(long_t.tmr));
  step_timer wait_tmr (.clk(MCLK), .rst_n(ARST_N), .t(wait_t.tmr));
  assign deb_t.step = ms_tick;
  assign min_t.step = ds_tick;
  assign long_t.step = ms_tick;
  assign wait_t.step = s_tick;

  // Merge write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic        blocked;
  logic        op;
  logic        op_val;
  logic        cls;
  logic        cls_val;
  logic [31:0] wval;
  logic [2:0]  deb_sel;

  assign deb_sel = st_reg.ctrl[contact_pkg::CTRL_DEB_LO +: 3];
  // Block acts only when allowed and the object is enabled
  assign blocked = st_reg.ctrl[contact_pkg::CTRL_ALLOW_BLK]
                 & st_reg.ctrl[contact_pkg::CTRL_BLK_EN] & st_reg.blk;

  // Next state: input path, event pipeline and register bus
  always_comb begin
    st_next = st_reg;
    op = 1'b0;
    op_val = 1'b0;
    cls = 1'b0;
    cls_val = 1'b0;
    wval = 32'h0000_0000;
    deb_t.load = 1'b0;
    deb_t.value = contact_pkg::DEB_MS[deb_sel];
    min_t.load = 1'b0;
    min_t.value = 16'h0000;
    long_t.load = 1'b0;
    long_t.value = st_reg.longt[15:0];
    wait_t.load = 1'b0;
    wait_t.value = st_reg.waitt;
    st_next.evt_valid = 1'b0;

    // Event sources: physical edge first, then trigger, then scan
    if (!deb_t.busy && CONTACT != st_reg.lvl) begin
      st_next.lvl = CONTACT;
      deb_t.load = 1'b1;
      if (!blocked) begin
        op = 1'b1;
        op_val = CONTACT;
      end
    end else if (st_reg.trig_pend) begin
      st_next.trig_pend = 1'b0;
      if (!blocked) begin
        op = 1'b1;
        op_val = st_reg.trig_val;
      end
    end else if (st_reg.scan_pend) begin
      st_next.scan_pend = 1'b0;
      if (!blocked) begin
        op = 1'b1;
        op_val = st_reg.lvl;
      end
    end

    // Minimum signal time filter
    if (op) begin
      if (st_reg.ctrl[contact_pkg::CTRL_MINSIG_EN]) begin
        st_next.mode = contact_pkg::ST_FILTER;
        st_next.pend_val = op_val;
        min_t.load = 1'b1;
        min_t.value = op_val ? st_reg.minsig[15:0] : st_reg.minsig[31:16];
      end else begin
        cls = 1'b1;
        cls_val = op_val;
      end
    end else if (st_reg.mode == contact_pkg::ST_FILTER && min_t.done) begin
      st_next.mode = contact_pkg::ST_IDLE;
      cls = 1'b1;
      cls_val = st_reg.pend_val;
    end

    // Short/long classification or direct event
    if (cls) begin
      if (st_reg.ctrl[contact_pkg::CTRL_LONG_EN]) begin
        if (cls_val) begin
          st_next.pressing = 1'b1;
          long_t.load = 1'b1;
        end else if (st_reg.pressing) begin
          st_next.pressing = 1'b0;
          st_next.evt_valid = 1'b1;
          st_next.evt_value = 1'b1;
          st_next.evt_long = 1'b0;
          st_next.sw_state = 1'b1;
        end
      end else begin
        st_next.evt_valid = 1'b1;
        st_next.evt_value = cls_val;
        st_next.evt_long = 1'b0;
        st_next.sw_state = cls_val;
      end
    end else if (st_reg.pressing && long_t.done) begin
      st_next.pressing = 1'b0;
      st_next.evt_valid = 1'b1;
      st_next.evt_value = 1'b1;
      st_next.evt_long = 1'b1;
      st_next.sw_state = 1'b1;
    end

    // Recovery wait over: sample the input
    if (wait_t.done && st_reg.ctrl[contact_pkg::CTRL_SCAN_EN]) begin
      st_next.scan_pend = 1'b1;
    end

    // Write address and data, taken in either order
    if (AWVALID && st_reg.awready) begin
      st_next.awready = 1'b0;
      st_next.aw_have = 1'b1;
      st_next.awaddr = AWADDR;
    end
    if (WVALID && st_reg.wready) begin
      st_next.wready = 1'b0;
      st_next.w_have = 1'b1;
      st_next.wdata = WDATA;
      st_next.wstrb = WSTRB;
    end

    // Register write once both halves are held
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = contact_pkg::RESP_OKAY;
      unique case (st_reg.awaddr)
        contact_pkg::OFS_CTRL: begin
          wval = merge(st_reg.ctrl, st_reg.wdata, st_reg.wstrb);
          st_next.ctrl = wval & contact_pkg::CTRL_MASK;
        end
        contact_pkg::OFS_BLOCK: begin
          if (st_reg.wstrb[0]) begin
            st_next.blk = st_reg.wdata[0];
          end
        end
        contact_pkg::OFS_TRIG: begin
          if (st_reg.wstrb[0] && st_reg.ctrl[contact_pkg::CTRL_TRIG_EN]) begin
            st_next.trig_pend = 1'b1;
            st_next.trig_val = st_reg.wdata[0];
          end
        end
        contact_pkg::OFS_MINSIG: begin
          st_next.minsig = merge(st_reg.minsig, st_reg.wdata, st_reg.wstrb);
        end
        contact_pkg::OFS_LONG: begin
          wval = merge(st_reg.longt, st_reg.wdata, st_reg.wstrb);
          st_next.longt = wval & contact_pkg::LONG_MASK;
        end
        contact_pkg::OFS_WAIT: begin
          wval = merge({16'h0000, st_reg.waitt}, st_reg.wdata, st_reg.wstrb);
          st_next.waitt = (wval[15:0] > contact_pkg::WAIT_MAX) ? contact_pkg::WAIT_MAX
                                                                : wval[15:0];
        end
        contact_pkg::OFS_RESCAN: begin
          if (st_reg.wstrb[0] && st_reg.ctrl[contact_pkg::CTRL_SCAN_EN]) begin
            if (st_reg.wdata[contact_pkg::RESCAN_NOW]) begin
              st_next.scan_pend = 1'b1;
            end
            if (st_reg.wdata[contact_pkg::RESCAN_RECOVER]) begin
              wait_t.load = 1'b1;
            end
          end
        end
        contact_pkg::OFS_STATUS: begin
          st_next.bresp = contact_pkg::RESP_OKAY;
        end
        default: begin
          st_next.bresp = contact_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Write response taken: reopen both channels
    if (st_reg.bvalid && BREADY) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // Read address taken: registered answer
    if (ARVALID && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = contact_pkg::RESP_OKAY;
      unique case (ARADDR)
        contact_pkg::OFS_CTRL:   st_next.rdata = st_reg.ctrl;
        contact_pkg::OFS_BLOCK:  st_next.rdata = {31'h0000_0000, st_reg.blk};
        contact_pkg::OFS_TRIG:   st_next.rdata = {31'h0000_0000, st_reg.trig_val};
        contact_pkg::OFS_MINSIG: st_next.rdata = st_reg.minsig;
        contact_pkg::OFS_LONG:   st_next.rdata = st_reg.longt;
        contact_pkg::OFS_WAIT:   st_next.rdata = {16'h0000, st_reg.waitt};
        contact_pkg::OFS_RESCAN: st_next.rdata = 32'h0000_0000;
        contact_pkg::OFS_STATUS: begin
          st_next.rdata = {24'h00_0000, wait_t.busy, deb_t.busy, blocked, st_reg.pressing,
                           (st_reg.mode == contact_pkg::ST_FILTER), st_reg.scan_pend,
                           st_reg.sw_state, st_reg.lvl};
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = contact_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rvalid && RREADY) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.ctrl <= contact_pkg::CTRL_RST;
      st_reg.minsig <= contact_pkg::MINSIG_RST;
      st_reg.longt <= contact_pkg::LONG_RST;
      st_reg.waitt <= contact_pkg::WAIT_RST;
      st_reg.mode <= contact_pkg::ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign AWREADY = st_reg.awready;
  assign WREADY = st_reg.wready;
  assign BRESP = st_reg.bresp;
  assign BVALID = st_reg.bvalid;
  assign ARREADY = st_reg.arready;
  assign RDATA = st_reg.rdata;
  assign RRESP = st_reg.rresp;
  assign RVALID = st_reg.rvalid;
  assign EVT_VALID = st_reg.evt_valid;
  assign EVT_VALUE = st_reg.evt_value;
  assign EVT_LONG = st_reg.evt_long;
  assign SWITCH_STATE = st_reg.sw_state;
endmodule
`default_nettype wire

// ### testbench/contact_button.sv
// Model of the push button or switch on the contact input.
// Assumes the bench calls move() just after a rising clock edge.
`default_nettype none
module contact_button (
  input  wire logic clk,
  output logic      contact
);
  timeunit 1ns;
  timeprecision 1ns;
  initial contact = 1'b0;

  // Bounce a few cycles, then settle at the new level
  task automatic move(input logic lvl, input int bounce);
    repeat (bounce) begin
      contact <= ~contact;
      @(posedge clk);
    end
    contact <= lvl;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/contact_input_conditioner_assertions.sv
// Checker on the ports of the contact input conditioner.
// Assumes a single MCLK domain with ARST_N as reset.
`default_nettype none
module contact_input_conditioner_assertions (
  input wire logic        MCLK,
  input wire logic        ARST_N,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic        EVT_VALID,
  input wire logic        EVT_VALUE,
  input wire logic        EVT_LONG,
  input wire logic        SWITCH_STATE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  // Event outputs
  property p_evt_pulse; EVT_VALID |=> !EVT_VALID; endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event pulse too long");
  property p_evt_state; EVT_VALID |-> SWITCH_STATE == EVT_VALUE; endproperty
  a_evt_state: assert property (p_evt_state) else $error("state differs from event");
  property p_state_hold; !EVT_VALID |-> $stable(SWITCH_STATE); endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved without event");
  property p_long_close; EVT_VALID && EVT_LONG |-> EVT_VALUE; endproperty
  a_long_close: assert property (p_long_close) else $error("long event with value 0");

  // Register bus handshakes
  property p_wr_taken; AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY && !WREADY ##1 BVALID; endproperty
  a_wr_taken: assert property (p_wr_taken) else $error("write answer late");
  property p_b_stands; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
  a_b_stands: assert property (p_b_stands) else $error("write answer dropped");
  property p_rd_answer; ARVALID && ARREADY |=> RVALID && !ARREADY; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_r_stands; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_r_stands: assert property (p_r_stands) else $error("read data dropped");
endmodule

bind contact_input_conditioner contact_input_conditioner_assertions i_chk (
  .MCLK(MCLK), .ARST_N(ARST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .EVT_VALID(EVT_VALID),
  .EVT_VALUE(EVT_VALUE), .EVT_LONG(EVT_LONG), .SWITCH_STATE(SWITCH_STATE));
`default_nettype wire

// ### testbench/contact_input_conditioner_bench.sv
// Self-checking bench for the contact input conditioner.
// Assumes 1 ms = 10 clocks (MS_CYCLES 10) and the button model.
`default_nettype none
module contact_input_conditioner_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, arst_n, contact;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        evt_valid, evt_value, evt_long, switch_state;
  int          n_mismatch, check_count;

  contact_button i_btn (.clk(mclk), .contact(contact));
  contact_input_conditioner #(.MS_CYCLES(10)) i_dut (
    .MCLK(mclk), .ARST_N(arst_n), .CONTACT(contact), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .EVT_VALID(evt_valid), .EVT_VALUE(evt_value), .EVT_LONG(evt_long), .SWITCH_STATE(switch_state));

  // 50 MHz clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Register write, expects OKAY
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk({31'h0, bvalid}, 32'h1);
    chk({30'h0, bresp}, {30'h0, contact_pkg::RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // Wait for one event and judge its value and kind
  task automatic wait_evt(input int max, input logic v, input logic lg);
    for (int n = 0; n < max; n++) begin
      @(negedge mclk);
      if (evt_valid === 1'b1) break;
    end
    chk({31'h0, evt_valid}, 32'h1);
    chk({30'h0, evt_value, evt_long}, {30'h0, v, lg});
  endtask

  task automatic no_evt(input int n);
    int hit;
    hit = 0;
    repeat (n) @(negedge mclk) if (evt_valid !== 1'b0) hit++;
    chk(32'(hit), 32'h0);
  endtask

  task automatic t_regs();
    rd(contact_pkg::OFS_CTRL, 32'h0000_0300, contact_pkg::RESP_OKAY);
    rd(contact_pkg::OFS_MINSIG, 32'h000a_000a, contact_pkg::RESP_OKAY);
    rd(contact_pkg::OFS_LONG, 32'h0000_0190, contact_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, contact_pkg::RESP_SLVERR);
    $display("t_regs done");
  endtask

  // Debounce choices 0 to 6: bouncy close, early open re-sampled after the time
  task automatic t_debounce();
    int ms [7] = '{10, 20, 30, 50, 70, 100, 150};
    for (int k = 0; k < 7; k++) begin
      wr(contact_pkg::OFS_CTRL, 32'(k) << contact_pkg::CTRL_DEB_LO);
      fork
        i_btn.move(1'b1, 3);
        wait_evt(30, 1'b1, 1'b0);
      join
      i_btn.move(1'b0, 0);
      no_evt(ms[k] * 10 - 20);
      wait_evt(40, 1'b0, 1'b0);
      no_evt(ms[k] * 10 + 20);
    end
    $display("t_debounce done");
  endtask

  task automatic t_block();
    wr(contact_pkg::OFS_CTRL, 32'h3);
    wr(contact_pkg::OFS_BLOCK, 32'h1);
    i_btn.move(1'b1, 0);
    no_evt(300);
    chk({31'h0, switch_state}, 32'h0);
    i_btn.move(1'b0, 0);
    no_evt(200);
    wr(contact_pkg::OFS_CTRL, 32'h2);
    fork
      i_btn.move(1'b1, 0);
      wait_evt(30, 1'b1, 1'b0);
    join
    i_btn.move(1'b0, 0);
    wait_evt(150, 1'b0, 1'b0);
    wr(contact_pkg::OFS_BLOCK, 32'h0);
    $display("t_block done");
  endtask

  task automatic t_trigger();
    wr(contact_pkg::OFS_CTRL, 32'h4);
    for (int v = 1; v >= 0; v--) begin
      fork
        wr(contact_pkg::OFS_TRIG, 32'(v));
        wait_evt(30, v[0], 1'b0);
      join
    end
    wr(contact_pkg::OFS_CTRL, 32'h0);
    wr(contact_pkg::OFS_TRIG, 32'h1);
    no_evt(50);
    $display("t_trigger done");
  endtask

  task automatic t_long();
    wr(contact_pkg::OFS_CTRL, 32'h8);
    wr(contact_pkg::OFS_LONG, 32'd20);
    fork
      i_btn.move(1'b1, 0);
      no_evt(150);
    join
    fork
      i_btn.move(1'b0, 0);
      wait_evt(20, 1'b1, 1'b0);
    join
    no_evt(200);
    fork
      i_btn.move(1'b1, 0);
      wait_evt(260, 1'b1, 1'b1);
    join
    i_btn.move(1'b0, 0);
    no_evt(300);
    $display("t_long done");
  endtask

  // Closing 300 ms, opening 200 ms; a short open is overtaken by a reclose
  task automatic t_minsig();
    wr(contact_pkg::OFS_CTRL, 32'h10);
    wr(contact_pkg::OFS_MINSIG, 32'h0002_0003);
    fork
      i_btn.move(1'b1, 0);
      no_evt(1500);
    join
    wait_evt(2500, 1'b1, 1'b0);
    i_btn.move(1'b0, 0);
    no_evt(300);
    i_btn.move(1'b1, 0);
    no_evt(1900);
    wait_evt(1500, 1'b1, 1'b0);
    $display("t_minsig done");
  endtask

  task automatic t_scan();
    wr(contact_pkg::OFS_CTRL, 32'h0);
    wr(contact_pkg::OFS_RESCAN, 32'h1);
    no_evt(50);
    wr(contact_pkg::OFS_CTRL, 32'h20);
    fork
      wr(contact_pkg::OFS_RESCAN, 32'h1);
      wait_evt(30, 1'b1, 1'b0);
    join
    wr(contact_pkg::OFS_WAIT, 32'h0000_ffff);
    rd(contact_pkg::OFS_WAIT, 32'h0000_7530, contact_pkg::RESP_OKAY);
    wr(contact_pkg::OFS_WAIT, 32'h0);
    fork
      wr(contact_pkg::OFS_RESCAN, 32'h2);
      wait_evt(30, 1'b1, 1'b0);
    join
    $display("t_scan done");
  endtask

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    arst_n = 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_debounce();
    t_block();
    t_trigger();
    t_long();
    t_minsig();
    t_scan();
    give_verdict();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
